// [core/sewc_map.vh]
// constants of the serial eeprom write control block
`ifndef SEWC_MAP_VH
`define SEWC_MAP_VH
`define SEWC_ADDR_W 10
`define SEWC_DATA_W 16
`define SEWC_DEPTH 1024
`define SEWC_OP_WRITE 2'h1
`define SEWC_OP_ERASE 2'h3
`define SEWC_OP_EXT 2'h0
`define SEWC_EXT_DIS 2'h0
`define SEWC_EXT_WALL 2'h1
`define SEWC_EXT_EALL 2'h2
`define SEWC_EXT_EN 2'h3
`define SEWC_CNT_SHORT 6'h0D
`define SEWC_CNT_LONG 6'h1D
`define SEWC_ERASED_WORD 16'hFFFF
`define SEWC_CLK_MHZ 125
`define SEWC_WRITE_TIME_US 4000
`define SEWC_WORD_CYCLES 20
`endif

// [core/sewc_mem.v]
// word memory of the eeprom array, registered read port
`timescale 1ns/100ps
`include "sewc_map.vh"
module sewc_mem
(
  input wire clk_i, // system clock
  input wire we_i, // write strobe
  input wire [9:0] waddr_i, // write address
  input wire [15:0] wdata_i, // write data
  input wire [9:0] raddr_i, // read address
  output reg [15:0] rdata_o // read data, registered
);
  reg [15:0] mem [0:`SEWC_DEPTH-1];

  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// [core/sewc_top.v]
// write-control logic of a 3-wire serial eeprom, 1024 x 16
`timescale 1ns/100ps
`include "sewc_map.vh"
module sewc_top
#(
  parameter WRITE_CYCLES = `SEWC_WRITE_TIME_US * `SEWC_CLK_MHZ - 1
)
(
  input wire clk_sys_i, // 125 MHz system clock
  input wire rst_i, // async reset, active high
  input wire chip_select_i, // chip select pin
  input wire serial_clock_in_i, // serial clock pin
  input wire serial_data_in_i, // serial data in pin
  input wire low_supply_i, // low-supply or power-up detector
  input wire [9:0] peek_addr_i, // array read address for inspection
  output reg [15:0] peek_data_o, // array word at peek address
  output reg serial_data_out_o, // serial data out level
  output reg serial_data_out_oe_o, // serial data out enable
  output reg busy_o, // internal write in progress
  output reg prog_enable_o // program-enable mode
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_PROG = 2'h2;
  localparam ST_FILL = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers
  reg [2:0] cs_s;
  reg [2:0] sk_s;
  reg [2:0] di_s;
  reg cs_q;
  reg sk_q;
  reg di_q;
  reg cs_d;
  reg sk_d;

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_s <= 3'h0;
      sk_s <= 3'h0;
      di_s <= 3'h0;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      di_q <= 1'b0;
      cs_d <= 1'b0;
      sk_d <= 1'b0;
    end
    else
    begin
      cs_s <= {cs_s[1:0], chip_select_i};
      sk_s <= {sk_s[1:0], serial_clock_in_i};
      di_s <= {di_s[1:0], serial_data_in_i};
      // a change counts once stages two and three agree
      if (cs_s[1] == cs_s[2])
        cs_q <= cs_s[2];
      if (sk_s[1] == sk_s[2])
        sk_q <= sk_s[2];
      if (di_s[1] == di_s[2])
        di_q <= di_s[2];
      cs_d <= cs_q;
      sk_d <= sk_q;
    end
  end

  wire sk_rise = sk_q & ~sk_d;
  wire cs_fall = ~cs_q & cs_d;

  ////////////////////////////////////////////////////////////////////////
  // instruction decode
  function [2:0] sewc_kind;
    input [1:0] op;
    input [1:0] ext;
    begin
      // 0 none/mode, 1 write, 2 erase, 3 write-all, 4 erase-all
      case (op)
        `SEWC_OP_WRITE: sewc_kind = 3'h1;
        `SEWC_OP_ERASE: sewc_kind = 3'h2;
        `SEWC_OP_EXT:
        begin
          if (ext == `SEWC_EXT_WALL)
            sewc_kind = 3'h3;
          else if (ext == `SEWC_EXT_EALL)
            sewc_kind = 3'h4;
          else
            sewc_kind = 3'h0;
        end
        default: sewc_kind = 3'h0;
      endcase
    end
  endfunction
  function [5:0] sewc_need;
    input [2:0] kind;
    begin
      if (kind == 3'h1 || kind == 3'h3)
        sewc_need = `SEWC_CNT_LONG;
      else
        sewc_need = `SEWC_CNT_SHORT;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control
  reg [1:0] state_reg;
  reg [5:0] count_reg;
  reg [27:0] shift_reg;
  reg [2:0] kind_reg;
  reg [9:0] addr_reg;
  reg [15:0] data_reg;
  reg [22:0] timer_reg;
  reg [9:0] fill_reg;
  reg mem_we;
  reg [9:0] mem_waddr;
  reg [15:0] mem_wdata;
  wire [15:0] mem_rdata;
  wire [1:0] rx_op = shift_reg[27:26];
  wire [1:0] rx_ext = shift_reg[25:24];
  wire [1:0] sh_op = shift_reg[11:10];
  wire [1:0] sh_ext = shift_reg[9:8];
  wire [2:0] rx_kind = sewc_kind(rx_op, rx_ext);
  wire [2:0] sh_kind = sewc_kind(sh_op, sh_ext);
  wire long_cmd = (count_reg == `SEWC_CNT_LONG);
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      count_reg <= 6'h00;
      shift_reg <= 28'h0000000;
      kind_reg <= 3'h0;
      addr_reg <= 10'h000;
      data_reg <= 16'h0000;
      timer_reg <= 23'h000000;
      fill_reg <= 10'h000;
      prog_enable_o <= 1'b0;
      busy_o <= 1'b0;
      mem_we <= 1'b0;
      mem_waddr <= 10'h000;
      mem_wdata <= 16'h0000;
      serial_data_out_o <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
    end
    else
    begin
      mem_we <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          count_reg <= 6'h00;
          // ignore dummy clocks until data in is high
          if (!low_supply_i && cs_q && sk_rise && di_q)
          begin
            state_reg <= ST_SHIFT;
            count_reg <= 6'h01;
            serial_data_out_oe_o <= 1'b0;
          end
        end
        ST_SHIFT:
        begin
          if (low_supply_i)
          begin
            state_reg <= ST_IDLE;
          end
          else if (cs_fall)
          begin
            state_reg <= ST_IDLE;
            // long form: opcode sits above address and data
            if (long_cmd && (rx_kind == 3'h1 || rx_kind == 3'h3))
            begin
              kind_reg <= rx_kind;
              addr_reg <= shift_reg[25:16];
              data_reg <= shift_reg[15:0];
              if (prog_enable_o)
              begin
                state_reg <= ST_PROG;
                busy_o <= 1'b1;
                timer_reg <= 23'h000000;
              end
            end
            else if (!long_cmd && count_reg == sewc_need(sh_kind))
            begin
              kind_reg <= sh_kind;
              addr_reg <= shift_reg[9:0];
              data_reg <= `SEWC_ERASED_WORD;
              if (sh_op == `SEWC_OP_EXT && sh_ext == `SEWC_EXT_EN)
                prog_enable_o <= 1'b1;
              else if (sh_op == `SEWC_OP_EXT && sh_ext == `SEWC_EXT_DIS)
                prog_enable_o <= 1'b0;
              else if (sh_kind != 3'h0 && prog_enable_o)
              begin
                state_reg <= ST_PROG;
                busy_o <= 1'b1;
                timer_reg <= 23'h000000;
              end
            end
          end
          else if (cs_q && sk_rise)
          begin
            shift_reg <= {shift_reg[26:0], di_q};
            // saturate so over-counts never alias to a valid length
            if (count_reg != 6'h3F)
              count_reg <= count_reg + 6'h01;
          end
        end
        ST_PROG:
        begin
          // serial clock and data in are not looked at here
          timer_reg <= timer_reg + 23'h000001;
          if (timer_reg == 23'h000000)
          begin
            if (kind_reg == 3'h1 || kind_reg == 3'h2)
            begin
              mem_we <= 1'b1;
              mem_waddr <= addr_reg;
              mem_wdata <= data_reg;
            end
            else
            begin
              fill_reg <= 10'h000;
              state_reg <= ST_FILL;
            end
          end
          else if (timer_reg >= WRITE_CYCLES[22:0])
          begin
            busy_o <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_FILL:
        begin
          // array fill walks one word a cycle, far inside the write time
          timer_reg <= timer_reg + 23'h000001;
          mem_we <= 1'b1;
          mem_waddr <= fill_reg;
          mem_wdata <= data_reg;
          fill_reg <= fill_reg + 10'h001;
          if (fill_reg == 10'h3FF)
            state_reg <= ST_PROG;
        end
        default: state_reg <= ST_IDLE;
      endcase
      // the detector wins over any mode change, even mid-write
      if (low_supply_i)
        prog_enable_o <= 1'b0;
      // status drive during verify, only when not shifting
      if (state_reg != ST_SHIFT && !(state_reg == ST_IDLE && cs_q &&
          sk_rise && di_q && !low_supply_i))
      begin
        serial_data_out_oe_o <= cs_q;
        serial_data_out_o <= ~busy_o;
      end
    end
  end
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      peek_data_o <= 16'h0000;
    else
      peek_data_o <= mem_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  sewc_mem u_mem
  (
    .clk_i(clk_sys_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(peek_addr_i),
    .rdata_o(mem_rdata)
  );
endmodule

// [bench/sewc_top_asserts.sv]
// assertion checker for the serial eeprom write control
`timescale 1ns/100ps
module sewc_chk
#(
  parameter WRITE_CYCLES = 200
)
(
  input wire clk_sys_i, // clock
  input wire rst_i, // reset
  input wire chip_select_i, // select pin
  input wire serial_clock_in_i, // serial clock pin
  input wire serial_data_in_i, // serial data pin
  input wire low_supply_i, // supply detector
  input wire busy_o, // write running
  input wire prog_enable_o, // mode
  input wire serial_data_out_o, // data out
  input wire serial_data_out_oe_o // data out enable
);
  localparam int T_ONE = WRITE_CYCLES + 1;
  // array fill takes 1024 cycles inside the timed write, so the longer wins
  localparam int T_ALL = (WRITE_CYCLES >= 1025) ? WRITE_CYCLES + 1 : 1026;
  reg [15:0] bcnt_reg;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // length of the current busy run, checked when it ends
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      bcnt_reg <= 16'h0000;
    else
      bcnt_reg <= busy_o ? bcnt_reg + 16'h0001 : 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  sequence start_seen;
    $rose(serial_clock_in_i) && serial_data_in_i && chip_select_i &&
    serial_data_out_oe_o && serial_data_out_o;
  endsequence
  AST_DO_STATUS: assert property (serial_data_out_oe_o |->
    serial_data_out_o == !$past(busy_o)) else $error("status level wrong");
  AST_IDLE_FLOAT: assert property (!chip_select_i [*8] |->
    !serial_data_out_oe_o) else $error("data out driven while deselected");
  AST_START_FLOAT: assert property (start_seen |-> ##[1:10]
    !serial_data_out_oe_o) else $error("data out not floated");
  AST_PROG_CS_LOW: assert property ($rose(busy_o) |->
    !chip_select_i) else $error("write began with select high");
  AST_PROG_MODE: assert property ($rose(busy_o) |->
    prog_enable_o) else $error("write began in disable mode");
  AST_BUSY_LEN: assert property ($fell(busy_o) |->
    bcnt_reg == T_ONE || bcnt_reg == T_ALL) else $error("busy length");
  AST_SUPPLY_DIS: assert property (low_supply_i |->
    ##[1:2] !prog_enable_o) else $error("mode kept at low supply");
  AST_SUPPLY_NOWRITE: assert property (low_supply_i |=>
    !$rose(busy_o)) else $error("write began at low supply");
  AST_MODE_CS: assert property ($rose(prog_enable_o) |->
    !chip_select_i) else $error("mode set before select fell");
  AST_BUSY_MODE: assert property (busy_o && !low_supply_i |=>
    $stable(prog_enable_o)) else $error("command taken while busy");
endmodule
bind sewc_top sewc_chk #(.WRITE_CYCLES(WRITE_CYCLES)) sewc_chk_inst (
  .clk_sys_i, .rst_i, .chip_select_i, .serial_clock_in_i,
  .serial_data_in_i, .low_supply_i, .busy_o, .prog_enable_o,
  .serial_data_out_o, .serial_data_out_oe_o);

// [bench/sewc_host.sv]
// host model driving the serial pins of the eeprom
`timescale 1ns/100ps
module sewc_host
(
  input wire clk_i, // system clock
  input wire sdo_i, // data out level
  input wire sdo_oe_i, // data out enable
  output reg cs_o, // chip select
  output reg sk_o, // serial clock
  output reg di_o // serial data
);
  initial
  begin
    cs_o = 1'b0;
    sk_o = 1'b0;
    di_o = 1'b0;
  end
  // one bit, 64 ns period; starts and ends on a falling clock edge
  task bit_out(input b);
  begin
    di_o = b;
    #32 sk_o = 1'b1;
    #32 sk_o = 1'b0;
  end
  endtask
  task frame(input [28:0] bits, input integer n);
    integer i;
  begin
    @(negedge clk_i);
    cs_o = 1'b1;
    repeat (8) @(negedge clk_i);
    bit_out(1'b0); // dummy clock
    for (i = 0; i < n; i = i + 1)
      bit_out(i < 29 ? bits[28 - i] : 1'b0);
    cs_o = 1'b0;
    di_o = 1'b0;
    repeat (12) @(negedge clk_i);
  end
  endtask
  // status poll holding select high; data in low so no start bit
  task poll(output integer n);
  begin
    n = 0;
    @(negedge clk_i);
    cs_o = 1'b1;
    di_o = 1'b0;
    repeat (8) @(negedge clk_i);
    while (!(sdo_oe_i && sdo_i) && n < 3000)
    begin
      sk_o = ~sk_o;
      repeat (4) @(negedge clk_i);
      n = n + 1;
    end
    sk_o = 1'b0;
    cs_o = 1'b0;
    repeat (12) @(negedge clk_i);
  end
  endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench of the serial eeprom write control
`timescale 1ns/100ps
module tb_top;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg low_supply_i = 1'b0;
  reg [9:0] peek_addr_i = 10'h000;
  reg pv = 1'b0;
  reg [2:0] pv_d = 3'h0;
  reg [15:0] q[$];
  reg [15:0] rnd = 16'h005E;
  reg [15:0] d;
  reg [15:0] d2;
  reg [9:0] a;
  integer num_errors = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer n;
  integer k;
  wire chip_select_i, serial_clock_in_i, serial_data_in_i;
  wire serial_data_out_o, serial_data_out_oe_o, busy_o, prog_enable_o;
  wire [15:0] peek_data_o;
  always #4 clk_sys_i = ~clk_sys_i;
  // short write time keeps the array fills quick
  sewc_top #(.WRITE_CYCLES(200)) sewc_top_inst (.clk_sys_i, .rst_i,
    .chip_select_i, .serial_clock_in_i, .serial_data_in_i, .low_supply_i,
    .peek_addr_i, .peek_data_o, .serial_data_out_o, .serial_data_out_oe_o,
    .busy_o, .prog_enable_o);
  sewc_host sewc_host_inst (.clk_i(clk_sys_i), .sdo_i(serial_data_out_o),
    .sdo_oe_i(serial_data_out_oe_o), .cs_o(chip_select_i),
    .sk_o(serial_clock_in_i), .di_o(serial_data_in_i));
  ////////////////////////////////////////////////////////////////////////////
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask
  task flag(input seen, input exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask
  task cmd(input [1:0] op, input [9:0] ad, input [15:0] dt,
    input integer nb);
    sewc_host_inst.frame({1'b1, op, ad, dt}, nb);
  endtask
  task wait_ready;
  begin
    sewc_host_inst.poll(n);
    flag(n < 3000, 1'b1);
  end
  endtask
  // note the expected word; the monitor compares once the read lands
  task expect_word(input [9:0] ad, input [15:0] w);
  begin
    @(negedge clk_sys_i);
    peek_addr_i = ad;
    q.push_back(w);
    pv = 1'b1;
    @(negedge clk_sys_i);
    pv = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  end
  endtask
  always @(posedge clk_sys_i)
  begin
    pv_d <= {pv_d[1:0], pv};
    if (pv_d[2])
      chk(peek_data_o, q.pop_front());
  end
  task test_done;
  begin
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rnd = lfsr(rnd);
    a = rnd[9:0];
    d = lfsr(rnd);
    d2 = lfsr(d);
    repeat (4) @(negedge clk_sys_i);
    flag(prog_enable_o, 1'b0);
    cmd(2'h1, a, d, 29);
    flag(busy_o, 1'b0);
    cmd(2'h0, 10'h300, 16'h0000, 13);
    flag(prog_enable_o, 1'b1);
    $display("test 1 done");
    cmd(2'h0, {2'h2, d[7:0]}, 16'h0000, 13);
    flag(busy_o, 1'b1);
    wait_ready;
    expect_word(a, 16'hFFFF);
    expect_word(~a, 16'hFFFF);
    cmd(2'h0, {2'h1, d2[7:0]}, d, 29);
    wait_ready;
    expect_word(a, d);
    expect_word(a ^ 10'h001, d);
    $display("test 2 done");
    // a disable sent mid-write must be ignored
    cmd(2'h1, a, d2, 29);
    cmd(2'h0, 10'h000, 16'h0000, 13);
    flag(prog_enable_o, 1'b1);
    wait_ready;
    expect_word(a, d2);
    expect_word(a ^ 10'h001, d);
    cmd(2'h3, a, 16'h0000, 13);
    wait_ready;
    expect_word(a, 16'hFFFF);
    $display("test 3 done");
    for (k = 0; k < 4; k = k + 1)
    begin
      cmd(k < 2 ? 2'h1 : 2'h3, a ^ 10'h001, d2,
        k == 0 ? 30 : k == 1 ? 13 : k == 2 ? 12 : 29);
      flag(busy_o, 1'b0);
    end
    expect_word(a ^ 10'h001, d);
    $display("test 4 done");
    cmd(2'h0, 10'h000, 16'h0000, 13);
    flag(prog_enable_o, 1'b0);
    cmd(2'h1, a, d, 29);
    flag(busy_o, 1'b0);
    cmd(2'h0, 10'h300, 16'h0000, 13);
    @(negedge clk_sys_i);
    low_supply_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    low_supply_i = 1'b0;
    flag(prog_enable_o, 1'b0);
    cmd(2'h1, a, d, 29);
    flag(busy_o, 1'b0);
    cmd(2'h0, 10'h300, 16'h0000, 13);
    cmd(2'h1, a, d, 29);
    wait_ready;
    expect_word(a, d);
    $display("test 5 done");
    test_done;
  end
endmodule
